/* File: include/bpss_pkg.sv */
// package for the backplane system services block
// assumes a 100 MHz core clock; backplane clock is derived from it
package bpss_pkg;
  // core clock
  localparam int unsigned CORE_CLOCK_HZ = 100_000_000;
  // backplane clock: nominal 10 MHz, 75 percent duty, +/-7 percent trim
  localparam int unsigned BUS_CLOCK_HZ = 10_000_000;
  localparam int unsigned BUS_DUTY_PERCENT = 75;
  localparam int unsigned TRIM_PERCENT = 7;
  // phase accumulator width and increments derived from the rates
  localparam int unsigned PHASE_W = 24;
  localparam logic [PHASE_W-1:0] PHASE_INC_NOM =
    PHASE_W'((64'(BUS_CLOCK_HZ) << PHASE_W) / 64'(CORE_CLOCK_HZ));
  localparam logic [PHASE_W-1:0] PHASE_INC_FAST =
    PHASE_W'((64'(BUS_CLOCK_HZ) * 64'(100 + TRIM_PERCENT) << PHASE_W)
      / (64'(CORE_CLOCK_HZ) * 64'd100));
  localparam logic [PHASE_W-1:0] PHASE_INC_SLOW =
    PHASE_W'((64'(BUS_CLOCK_HZ) * 64'(100 - TRIM_PERCENT) << PHASE_W)
      / (64'(CORE_CLOCK_HZ) * 64'd100));
  // low phase of the clock is the first quarter of each period
  localparam logic [PHASE_W-1:0] PHASE_LOW_END =
    PHASE_W'(((64'd100 - 64'(BUS_DUTY_PERCENT)) << PHASE_W) / 64'd100);
  // time-out limit
  localparam int unsigned TIMEOUT_MAX = 256;
  localparam int unsigned TIMEOUT_W = 9;
  localparam logic [TIMEOUT_W-1:0] TIMEOUT_RESET = 9'h100;
  // transfer-mode code driven with a time-out acknowledge
  localparam logic [1:0] TM_TIMEOUT = 2'h2;
  // clock trim and margin select codes
  typedef enum logic [1:0] {
    BPSS_TRIM_NOM = 2'h0,
    BPSS_TRIM_UP = 2'h1,
    BPSS_TRIM_DOWN = 2'h2
  } bpss_trim_t;
  // power-up test sequence
  typedef enum logic [2:0] {
    BPSS_ST_SELF = 3'h0,
    BPSS_ST_BUS = 3'h1,
    BPSS_ST_BOARDS = 3'h3,
    BPSS_ST_DONE = 3'h2,
    BPSS_ST_HALT = 3'h6
  } bpss_state_t;
  // front panel lamp positions
  localparam int unsigned LAMP_ATTN = 0;
  localparam int unsigned LAMP_SETUP = 1;
  localparam int unsigned LAMP_RUN = 2;
  // console select codes
  localparam logic CONSOLE_SERIAL = 1'b0;
  localparam logic CONSOLE_DISPLAY = 1'b1;
  // rotary switch width and default slot count
  localparam int unsigned SWITCH_W = 4;
  localparam int unsigned SLOTS_DEFAULT = 16;
endpackage

/* File: rtl/bpss_top.sv */
// backplane system services: bus clock, time-out, power lines, test sequence
// assumes one 100 MHz clock; strobe, ac/dc power and rotary switch pins pass two-flop synchronisers
//
// Overview of operation
// - The block makes the single 10 MHz backplane clock with 75 percent duty.
// - Software can raise or lower the bus clock rate by 7 percent.
// - With time-out enabled, cycles are counted from start strobe to acknowledge.
// - Past the programmed limit (up to 256) the block drives acknowledge with the time-out code.
// - An ac power-fail assertion posts an event to each installed processor.
// - While dc out-of-tolerance is active a system-wide reset is driven.
// - A margin output moves the five-volt rail up or down by 7 percent.
// - An ac shutoff output cuts system ac power when asserted.
// - A programmable interval timer posts periodic events to chosen processors.
// - After power-up: self-test, bus test, board tests, then lamps summarise.
// - Board lamps light at power-up and go out only after that board passes.
// - The rotary switch picks which serial port is the remote diagnostic port.
// - At boot the rotary switch picks the console: serial port or display.
// - Board reset returns every register to power-up state and resets the processor.
`default_nettype none
module bpss_top
  import bpss_pkg::*;
#(
  parameter int unsigned SLOTS = SLOTS_DEFAULT,
  parameter int unsigned TIMER_W = 16
) (
  // clock and board reset
  input wire logic clock,
  input wire logic rst_b,
  // backplane clock
  output logic bus_clock,
  input wire logic [1:0] clock_trim,
  // time-out recovery
  input wire logic timeout_enable,
  input wire logic [TIMEOUT_W-1:0] timeout_limit,
  input wire logic start_strobe,
  input wire logic ack_strobe,
  output logic ack_drive,
  output logic [1:0] tm_drive,
  output logic timeout_seen,
  // power supply lines
  input wire logic ac_power_fail_in,
  input wire logic dc_out_of_tolerance_in,
  input wire logic [SLOTS-1:0] cpu_installed,
  output logic [SLOTS-1:0] power_fail_event,
  output logic system_reset,
  input wire logic [1:0] margin_select,
  output logic [1:0] margin_out,
  input wire logic shutoff_request,
  output logic ac_shutoff_out,
  // interval timer
  input wire logic [TIMER_W-1:0] timer_period,
  input wire logic [SLOTS-1:0] timer_targets,
  output logic [SLOTS-1:0] timer_event,
  // test sequence and lamps
  input wire logic test_pass,
  input wire logic test_fail,
  input wire logic setup_ok,
  input wire logic [SLOTS-1:0] board_pass,
  output logic [1:0] test_phase,
  output logic [2:0] panel_lamps,
  output logic [SLOTS-1:0] board_lamp,
  // rotary switch and console
  input wire logic [SWITCH_W-1:0] rotary_switch,
  output logic diag_port_select,
  output logic console_select,
  output logic processor_reset_b
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_W = 4 + SWITCH_W;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  wire [SYNC_W-1:0] pins = {rotary_switch, start_strobe, ack_strobe,
                            ac_power_fail_in, dc_out_of_tolerance_in};
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pins;
      sync_b <= sync_a;
    end
  end
  wire dc_out_of_tolerance_in_s = sync_b[0];
  wire ac_power_fail_in_s = sync_b[1];
  wire ack_s = sync_b[2];
  wire start_s = sync_b[3];
  wire [SWITCH_W-1:0] switch_s = sync_b[SYNC_W-1:4];

  // ---------------------------------------------------------------
  // backplane clock generator
  // ---------------------------------------------------------------
  logic [PHASE_W-1:0] phase;
  wire [PHASE_W-1:0] phase_inc =
    (clock_trim == BPSS_TRIM_UP) ? PHASE_INC_FAST :
    (clock_trim == BPSS_TRIM_DOWN) ? PHASE_INC_SLOW :
    PHASE_INC_NOM;
  wire next_bus_clock = (phase + phase_inc) >= PHASE_LOW_END;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      phase <= '0;
      bus_clock <= 1'b0;
    end else begin
      phase <= phase + phase_inc;
      bus_clock <= next_bus_clock;
    end
  end

  // ---------------------------------------------------------------
  // transfer time-out
  // ---------------------------------------------------------------
  logic start_d;
  logic bus_clock_d;
  logic active;
  logic [TIMEOUT_W-1:0] count;
  wire bus_edge = bus_clock & ~bus_clock_d;
  wire start_rise = start_s & ~start_d;
  wire expired = active && (count >= timeout_limit);
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      start_d <= 1'b0;
      bus_clock_d <= 1'b0;
      active <= 1'b0;
      count <= '0;
      ack_drive <= 1'b0;
      tm_drive <= 2'h0;
      timeout_seen <= 1'b0;
    end else begin
      start_d <= start_s;
      bus_clock_d <= bus_clock;
      ack_drive <= 1'b0;
      tm_drive <= 2'h0;
      if (!timeout_enable) begin
        active <= 1'b0;
        count <= '0;
      end else if (start_rise) begin
        active <= 1'b1;
        count <= '0;
      end else if (ack_s && active) begin
        active <= 1'b0;
        count <= '0;
      end else if (expired) begin
        active <= 1'b0;
        count <= '0;
        ack_drive <= 1'b1;
        tm_drive <= TM_TIMEOUT;
        timeout_seen <= 1'b1;
      end else if (active && bus_edge) begin
        count <= count + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // power supply lines
  // ---------------------------------------------------------------
  logic ac_power_fail_in_d;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ac_power_fail_in_d <= 1'b0;
      power_fail_event <= '0;
      system_reset <= 1'b1;
      margin_out <= 2'h0;
      ac_shutoff_out <= 1'b0;
    end else begin
      ac_power_fail_in_d <= ac_power_fail_in_s;
      power_fail_event <= (ac_power_fail_in_s & ~ac_power_fail_in_d) ? cpu_installed : '0;
      system_reset <= dc_out_of_tolerance_in_s;
      margin_out <= margin_select;
      ac_shutoff_out <= shutoff_request;
    end
  end

  // ---------------------------------------------------------------
  // interval timer
  // ---------------------------------------------------------------
  logic [TIMER_W-1:0] timer_count;
  wire timer_wrap = (timer_period != '0) && (timer_count >= timer_period - 1'b1);
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      timer_count <= '0;
      timer_event <= '0;
    end else begin
      timer_count <= timer_wrap ? '0 : timer_count + 1'b1;
      timer_event <= timer_wrap ? timer_targets : '0;
    end
  end

  // ---------------------------------------------------------------
  // power-up test sequence and lamps
  // ---------------------------------------------------------------
  bpss_state_t state;
  bpss_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      BPSS_ST_SELF: begin
        if (test_fail) next_state = BPSS_ST_HALT;
        else if (test_pass) next_state = BPSS_ST_BUS;
      end
      BPSS_ST_BUS: begin
        if (test_fail) next_state = BPSS_ST_HALT;
        else if (test_pass) next_state = BPSS_ST_BOARDS;
      end
      BPSS_ST_BOARDS: begin
        if (test_fail) next_state = BPSS_ST_HALT;
        else if (test_pass) next_state = BPSS_ST_DONE;
      end
      BPSS_ST_DONE: next_state = BPSS_ST_DONE;
      BPSS_ST_HALT: next_state = BPSS_ST_HALT;
      default: next_state = BPSS_ST_HALT;
    endcase
  end
  wire done = (state == BPSS_ST_DONE);
  // all panel lamps stay lit until the sequence completes; a halt leaves them lit
  wire [2:0] next_lamps = done ? {1'b1, ~setup_ok, 1'b0} : 3'h7;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= BPSS_ST_SELF;
      panel_lamps <= 3'h7;
      board_lamp <= '1;
    end else begin
      state <= next_state;
      panel_lamps <= next_lamps;
      if (state == BPSS_ST_BOARDS) begin
        board_lamp <= board_lamp & ~board_pass;
      end
    end
  end
  assign test_phase = state[1:0];

  // ---------------------------------------------------------------
  // rotary switch roles, caught once after reset
  // ---------------------------------------------------------------
  logic [1:0] settle;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      settle <= 2'h0;
      diag_port_select <= 1'b0;
      console_select <= CONSOLE_SERIAL;
    end else if (settle != 2'h3) begin
      settle <= settle + 1'b1;
      diag_port_select <= switch_s[0];
      console_select <= switch_s[1] ? CONSOLE_DISPLAY : CONSOLE_SERIAL;
    end
  end
  assign processor_reset_b = rst_b;

endmodule
`default_nettype wire

/* File: dv/bpss_checker.sv */
// assertions on the system services block ports
// assumes bpss_top with one core clock and synchronous reset
`default_nettype none
module bpss_checker
  import bpss_pkg::*;
#(
  parameter int unsigned SLOTS = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // watched lines
  input wire logic bus_clock,
  input wire logic ack_drive,
  input wire logic [1:0] tm_drive,
  input wire logic timeout_seen,
  input wire logic [SLOTS-1:0] cpu_installed,
  input wire logic [SLOTS-1:0] power_fail_event,
  input wire logic dc_out_of_tolerance_in,
  input wire logic system_reset,
  input wire logic [SLOTS-1:0] board_pass,
  input wire logic [SLOTS-1:0] board_lamp,
  input wire logic [1:0] test_phase,
  input wire logic [2:0] panel_lamps
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // length of the current high phase
  logic [7:0] hi_cnt;
  always_ff @(posedge clock) begin
    hi_cnt <= (bus_clock && rst_b) ? hi_cnt + 8'h01 : 8'h00;
  end
  sequence s_dc_out_of_tolerance_in_held; dc_out_of_tolerance_in [*3]; endsequence
  sequence s_timeout_ack; ack_drive ##1 (!ack_drive && timeout_seen); endsequence
  property p_duty; $fell(bus_clock) |-> hi_cnt >= 8'h06 && hi_cnt <= 8'h09; endproperty
  a_duty: assert property (p_duty) else $error("bus clock high phase");
  property p_tm; ack_drive |-> tm_drive == TM_TIMEOUT; endproperty
  a_tm: assert property (p_tm) else $error("time-out code");
  property p_pulse; ack_drive |-> s_timeout_ack; endproperty
  a_pulse: assert property (p_pulse) else $error("time-out pulse");
  property p_pfail; power_fail_event != '0 |-> power_fail_event == $past(cpu_installed); endproperty
  a_pfail: assert property (p_pfail) else $error("power fail mask");
  property p_dc_out_of_tolerance_in; s_dc_out_of_tolerance_in_held |=> system_reset; endproperty
  a_dc_out_of_tolerance_in: assert property (p_dc_out_of_tolerance_in) else $error("no system reset");
  property p_phase; $changed(test_phase) |-> test_phase == 2'h2
    || {$past(test_phase), test_phase} inside {4'h1, 4'h7}; endproperty
  a_phase: assert property (p_phase) else $error("test order");
  property p_lamp; (~board_lamp & $past(board_lamp)
    & ~($past(board_pass) | $past(board_pass, 2))) == '0; endproperty
  a_lamp: assert property (p_lamp) else $error("lamp off early");
  property p_rst; disable iff (1'b0) !rst_b |=> panel_lamps == 3'h7
    && board_lamp == '1 && system_reset; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind bpss_top bpss_checker #(.SLOTS(SLOTS)) i_bpss_checker (.*);
`default_nettype wire

/* File: dv/bpss_partner.sv */
// bus slave model: acknowledges a transfer start after a set delay
// assumes start pulses on the core clock; delay 0 never answers
`default_nettype none
module bpss_partner (
  // clock and bus lines
  input wire logic clock,
  input wire logic start_strobe,
  input wire logic [15:0] ack_delay,
  output var logic ack_strobe
);
  logic [15:0] left = 16'h0000;
  initial ack_strobe = 1'b0;
  always @(posedge clock) begin
    ack_strobe <= (left == 16'h0001);
    left <= start_strobe ? ack_delay : (left != 16'h0000 ? left - 16'h0001 : left);
  end
endmodule
`default_nettype wire

/* File: dv/bpss_tb_top.sv */
// bench for the system services block with a bus slave model
// assumes bpss_pkg, bpss_top, bpss_partner and the bound checker
`default_nettype none
module bpss_tb_top
  import bpss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst_b = 1'b0, timeout_enable = 1'b0, start_strobe = 1'b0;
  logic ack_strobe, ac_power_fail_in = 1'b0, dc_out_of_tolerance_in = 1'b0;
  logic shutoff_request = 1'b0, test_pass = 1'b0, test_fail = 1'b0, setup_ok = 1'b1;
  logic [1:0] clock_trim = 2'h0, margin_select = 2'h0;
  logic [8:0] timeout_limit = 9'h001;
  logic [3:0] cpu_installed = 4'hA, timer_targets = 4'h5, board_pass = 4'h0;
  logic [3:0] rotary_switch = 4'h0;
  logic [15:0] timer_period = 16'h0000, ack_delay = 16'h0000;
  logic bus_clock, ack_drive, timeout_seen, system_reset, ac_shutoff_out;
  logic diag_port_select, console_select, processor_reset_b;
  logic [1:0] tm_drive, margin_out, test_phase;
  logic [2:0] panel_lamps;
  logic [3:0] power_fail_event, board_lamp, timer_event;
  int num_errors = 0, tests_run = 0, cyc = 0, hit;
  bpss_top #(.SLOTS(4)) i_bpss_top (.*);
  bpss_partner i_bpss_partner (.*);
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cy(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  // one-cycle pulse: 0 start, 1 pass, 2 fail
  task automatic pulse(input int w);
    @(posedge clock);
    start_strobe <= (w == 0);
    test_pass <= (w == 1);
    test_fail <= (w == 2);
    @(posedge clock);
    {start_strobe, test_pass, test_fail} <= 3'h0;
  endtask
  task automatic watch(input int k);
    hit = -1;
    for (int i = 0; i < k; i++) begin
      cy(1);
      if (ack_drive === 1'b1 && hit < 0) hit = i;
    end
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_rst(input logic [3:0] sw);
    @(posedge clock) rotary_switch <= sw;
    @(posedge clock) rst_b <= 1'b0;
    cy(12);
    chk({panel_lamps, board_lamp, system_reset, processor_reset_b}, 9'h1FE);
    @(posedge clock) rst_b <= 1'b1;
    cy(8);
    @(posedge clock) rotary_switch <= ~sw;
    cy(6);
    chk(diag_port_select, sw[0]);
    chk(console_select, sw[1]);
  endtask
  task automatic t_tests();
    t_rst(4'h2);
    chk(test_phase, 2'h0);
    pulse(1);
    cy(2);
    chk(test_phase, 2'h1);
    @(posedge clock) board_pass <= 4'h2;
    cy(2);
    chk(board_lamp, 4'hF);
    @(posedge clock) board_pass <= 4'h0;
    pulse(1);
    cy(2);
    chk(test_phase, 2'h3);
    @(posedge clock) board_pass <= 4'h1;
    cy(2);
    chk(board_lamp, 4'hE);
    @(posedge clock) board_pass <= 4'h0;
    pulse(1);
    pulse(1);
    cy(3);
    chk({test_phase, panel_lamps}, 5'h14);
    t_rst(4'h1);
    pulse(2);
    cy(3);
    chk({test_phase, panel_lamps}, 5'h17);
  endtask
  task automatic t_clock();
    int lo[4] = '{198, 184, 212, 198};
    int t0;
    for (int c = 0; c < 4; c++) begin
      @(posedge clock) clock_trim <= c[1:0];
      cy(30);
      @(posedge bus_clock) t0 = cyc;
      repeat (20) @(posedge bus_clock);
      chk(cyc - t0 >= lo[c] && cyc - t0 <= lo[c] + 4, 1'b1);
    end
  endtask
  task automatic t_timeout(input logic [8:0] lim, input logic [15:0] dly);
    int n;
    n = lim;
    @(posedge clock) timeout_limit <= lim;
    ack_delay <= dly;
    timeout_enable <= 1'b1;
    pulse(0);
    watch(n * 10 + 40);
    if (dly == 16'h0000) begin
      chk(hit >= (n - 1) * 10 && hit <= n * 10 + 15, 1'b1);
      chk(timeout_seen, 1'b1);
    end else begin
      chk(hit, -1);
    end
  endtask
  task automatic t_restart();
    @(posedge clock) ack_delay <= 16'h0000;
    timeout_limit <= 9'h014;
    pulse(0);
    cy(100);
    pulse(0);
    watch(260);
    chk(hit >= 180 && hit <= 215, 1'b1);
    @(posedge clock) timeout_enable <= 1'b0;
    pulse(0);
    watch(260);
    chk(hit, -1);
  endtask
  task automatic t_power();
    int cnt;
    cnt = 0;
    @(posedge clock) ac_power_fail_in <= 1'b1;
    repeat (8) begin
      cy(1);
      if (power_fail_event !== 4'h0) begin
        cnt++;
        chk(power_fail_event, 4'hA);
      end
    end
    chk(cnt, 1);
    @(posedge clock) ac_power_fail_in <= 1'b0;
    dc_out_of_tolerance_in <= 1'b1;
    cy(5);
    chk(system_reset, 1'b1);
    @(posedge clock) dc_out_of_tolerance_in <= 1'b0;
    cy(5);
    chk(system_reset, 1'b0);
    for (int m = 0; m < 3; m++) begin
      @(posedge clock) margin_select <= m[1:0];
      shutoff_request <= m[0];
      cy(4);
      chk({margin_out, ac_shutoff_out}, {m[1:0], m[0]});
    end
  endtask
  task automatic t_timer();
    int cnt;
    cnt = 0;
    @(posedge clock) timer_period <= 16'h0005;
    cy(5);
    repeat (60) begin
      cy(1);
      if (timer_event !== 4'h0) begin
        cnt++;
        chk(timer_event, 4'h5);
      end
    end
    chk(cnt >= 10 && cnt <= 12, 1'b1);
  endtask
  initial begin
    t_tests();
    t_clock();
    t_timeout(9'h001, 16'h0000);
    t_timeout(9'h100, 16'h0000);
    t_timeout(9'h014, 16'h0032);
    t_restart();
    t_power();
    t_timer();
    end_of_test();
  end
endmodule
`default_nettype wire
